// ===== bml_ctrl_model.sv
/*
  bml_ctrl_model.sv - far-side controller: pulse demand register and the
  pull-ups on the open-drain fault and warning pins.
  Assumes the sequence sets the demand just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none

module bml_ctrl_model (
  // clock
  input  wire logic       mclk,
  // pulse demand
  input  wire logic [3:0] pwm_set,
  output var  logic [3:0] pwm_in,
  // open-drain pins
  input  wire logic       fault_n_o,
  input  wire logic       fault_n_oe,
  output wire logic       fault_n_i,
  input  wire logic       overheat_warn_n_o,
  input  wire logic       overheat_warn_n_oe,
  output wire logic       overheat_warn_n_i
);
  // timer output flop, so demand moves one edge after it is asked for
  initial pwm_in = 4'h0;
  always @(posedge mclk) begin
    pwm_in <= pwm_set;
  end

  // a released pin rises to the pull-up, never keeps the last level
  assign fault_n_i         = fault_n_oe ? fault_n_o : 1'b1;
  assign overheat_warn_n_i = overheat_warn_n_oe ? overheat_warn_n_o : 1'b1;
endmodule // bml_ctrl_model

`default_nettype wire

// ===== bml_map.vh
/*
  bml_map.vh - constants for the bridge mode input logic: register
  offsets, field positions, reset values and mode codes.
  Assumes inclusion by bare name from the design files and the testbench.
*/
`ifndef BML_MAP_VH
`define BML_MAP_VH

// register byte offsets, one aligned 32-bit word each
`define BML_OFS_CTRL        4'h0
`define BML_OFS_STATUS      4'h4
`define BML_OFS_IRQ_STAT    4'h8
`define BML_OFS_IRQ_MASK    4'hC
`define BML_ADDR_W          4

// control register fields
`define BML_CTRL_HALT_BIT   0
`define BML_CTRL_RST        1'h0

// status register fields
`define BML_ST_MODE_LSB     0
`define BML_ST_MODE_MSB     2
`define BML_ST_RST_AB_BIT   3
`define BML_ST_RST_CD_BIT   4
`define BML_ST_LATCH_AB_BIT 5
`define BML_ST_LATCH_CD_BIT 6
`define BML_ST_RSVD_BIT     7
`define BML_ST_TRIP_LSB     8
`define BML_ST_TRIP_MSB     11
`define BML_ST_FAULT_BIT    12
`define BML_ST_WARN_BIT     13

// interrupt status / mask fields
`define BML_IRQ_W           4
`define BML_IRQ_LATCH_BIT   0
`define BML_IRQ_CBC_BIT     1
`define BML_IRQ_HOT_BIT     2
`define BML_IRQ_RSVD_BIT    3
`define BML_IRQ_RST         4'h0

// mode codes on {bit2, bit1, bit0}
`define BML_MODE_DUAL_CBC   3'h0
`define BML_MODE_DUAL_LATCH 3'h1
`define BML_MODE_PARALLEL   3'h2
`define BML_MODE_COMPL      3'h3
`define BML_MODE_RSVD_BIT   2

// axi responses
`define BML_RESP_OKAY       2'h0
`define BML_RESP_SLVERR     2'h2

// synchronised pin vector layout
`define BML_SY_W            16
`define BML_SY_PWM_LSB      0
`define BML_SY_PWM_MSB      3
`define BML_SY_RST_AB       4
`define BML_SY_RST_CD       5
`define BML_SY_MODE_LSB     6
`define BML_SY_MODE_MSB     8
`define BML_SY_OC_LSB       9
`define BML_SY_OC_MSB       12
`define BML_SY_HOT          13
`define BML_SY_FAULT        14
`define BML_SY_WARN         15
`define BML_SY_RST          16'h0000

`endif

// ===== bml_sync.v
/*
  bml_sync.v - two-flop synchroniser for a vector of unrelated pin levels.
  Assumes each bit is an independent level; no bus coherency is implied.
*/
`timescale 1ns/10ps
`default_nettype none

module bml_sync #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             mclk,
  input  wire             reset,
  // pin levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  // first stage is read only by the second stage
  always @(posedge mclk) begin
    if (reset) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // bml_sync

`default_nettype wire

// ===== bml_top.v
/*
  bml_top.v - logic-level input section of a dual full-bridge driver:
  routes four pulse inputs to four half-bridges, pair resets, mode
  decode with current-limit policy, open-drain fault and warning pins,
  and an AXI4-Lite register slave with a masked interrupt.
  Assumes all pins are asynchronous to mclk; overcurrent and
  overtemperature detectors are digital levels from the analog side.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bml_map.vh"

module bml_top (
  // clock and reset
  input  wire        mclk,
  input  wire        reset,
  // pulse and pair reset pins
  input  wire [3:0]  pwm_in,
  input  wire        pair_one_reset_n,
  input  wire        pair_two_reset_n,
  // mode select pins
  input  wire        mode_sel_bit0,
  input  wire        mode_sel_bit1,
  input  wire        mode_sel_bit2,
  // detector levels from the power stage
  input  wire [3:0]  oc_detect,
  input  wire        hot_detect,
  // half-bridge commands
  output reg  [3:0]  hb_drive,
  output reg  [3:0]  hb_enable,
  // open-drain fault pin
  input  wire        fault_n_i,
  output reg         fault_n_o,
  output reg         fault_n_oe,
  // open-drain overtemperature warning pin
  input  wire        overheat_warn_n_i,
  output reg         overheat_warn_n_o,
  output reg         overheat_warn_n_oe,
  // axi4-lite write address and data
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // interrupt
  output reg         irq
);

  // half-bridge demand for one pair from its two inputs under a mode
  function [1:0] pair_demand;
    input [2:0] mode;
    input       pwm_first;
    input       pwm_second;
    begin
      case (mode)
        `BML_MODE_DUAL_CBC,
        `BML_MODE_DUAL_LATCH: pair_demand = {pwm_second, pwm_first};
        `BML_MODE_PARALLEL:   pair_demand = {pwm_first, pwm_first};
        `BML_MODE_COMPL:      pair_demand = {~pwm_first, pwm_first};
        default:              pair_demand = 2'h0;
      endcase
    end
  endfunction

  // true where overcurrent is limited per cycle rather than latched
  function is_cbc;
    input [2:0] mode;
    begin
      is_cbc = (mode == `BML_MODE_DUAL_CBC) || (mode == `BML_MODE_PARALLEL) ||
               (mode == `BML_MODE_COMPL);
    end
  endfunction

  // synchronised pins
  wire [`BML_SY_W-1:0] sy;
  wire [3:0]           pwm_s;
  wire                 rst_ab_n_s;
  wire                 rst_cd_n_s;
  wire [2:0]           mode_s;
  wire [3:0]           oc_s;
  wire                 hot_s;

  bml_sync #(
    .WIDTH   (`BML_SY_W),
    .RST_VAL (`BML_SY_RST)
  ) u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in ({overheat_warn_n_i, fault_n_i, hot_detect, oc_detect,
                mode_sel_bit2, mode_sel_bit1, mode_sel_bit0,
                pair_two_reset_n, pair_one_reset_n, pwm_in}),
    .sync_out (sy)
  );

  assign pwm_s      = sy[`BML_SY_PWM_MSB:`BML_SY_PWM_LSB];
  assign rst_ab_n_s = sy[`BML_SY_RST_AB];
  assign rst_cd_n_s = sy[`BML_SY_RST_CD];
  assign mode_s     = sy[`BML_SY_MODE_MSB:`BML_SY_MODE_LSB];
  assign oc_s       = sy[`BML_SY_OC_MSB:`BML_SY_OC_LSB];
  assign hot_s      = sy[`BML_SY_HOT];

  // registers and protection state
  reg                   halt_r;
  reg  [`BML_IRQ_W-1:0] irq_stat_r;
  reg  [`BML_IRQ_W-1:0] irq_mask_r;
  reg  [3:0]            trip_r;
  reg                   latch_ab_r;
  reg                   latch_cd_r;
  reg  [3:0]            demand_d_r;
  reg                   hot_d_r;
  reg                   rsvd_d_r;
  reg                   latch_any_d_r;

  // combinational protection view
  wire [3:0] demand;
  wire [3:0] pair_run;
  wire       rsvd_mode;
  wire       cbc_mode;
  wire [3:0] new_cycle;
  wire [3:0] trip_set;
  wire       latch_any;
  wire       fault_now;

  assign rsvd_mode = mode_s[`BML_MODE_RSVD_BIT];
  assign cbc_mode  = is_cbc(mode_s);
  assign demand    = {pair_demand(mode_s, pwm_s[2], pwm_s[3]),
                      pair_demand(mode_s, pwm_s[0], pwm_s[1])};
  assign pair_run  = {{2{rst_cd_n_s}}, {2{rst_ab_n_s}}};
  assign new_cycle = demand & ~demand_d_r;
  assign trip_set  = oc_s & pair_run & {4{cbc_mode}};
  assign latch_any = latch_ab_r | latch_cd_r;
  assign fault_now = latch_any | rsvd_mode;

  // cycle-by-cycle limit: a tripped half stays off until its next
  // rising demand edge; a trip seen on that same edge wins
  always @(posedge mclk) begin
    if (reset) begin
      trip_r     <= 4'h0;
      demand_d_r <= 4'h0;
    end else begin
      trip_r     <= ((trip_r & ~new_cycle) | trip_set) & pair_run;
      demand_d_r <= demand;
    end
  end

  // latched shutdown per pair, cleared only by holding that pair's reset
  always @(posedge mclk) begin
    if (reset) begin
      latch_ab_r <= 1'b0;
      latch_cd_r <= 1'b0;
    end else begin
      if (!rst_ab_n_s)
        latch_ab_r <= 1'b0;
      else if ((mode_s == `BML_MODE_DUAL_LATCH) && (|oc_s[1:0]))
        latch_ab_r <= 1'b1;
      if (!rst_cd_n_s)
        latch_cd_r <= 1'b0;
      else if ((mode_s == `BML_MODE_DUAL_LATCH) && (|oc_s[3:2]))
        latch_cd_r <= 1'b1;
    end
  end

  // half-bridge outputs; a half in reset is disabled with both
  // switches off, which is the safe state on any doubt
  always @(posedge mclk) begin
    if (reset) begin
      hb_drive  <= 4'h0;
      hb_enable <= 4'h0;
    end else begin
      hb_enable <= pair_run & ~{{2{latch_cd_r}}, {2{latch_ab_r}}} &
                   {4{~rsvd_mode & ~halt_r}};
      hb_drive  <= demand & pair_run & ~trip_r & ~trip_set &
                   ~{{2{latch_cd_r}}, {2{latch_ab_r}}} &
                   {4{~rsvd_mode & ~halt_r}};
    end
  end

  // open-drain pins: data held low, enable pulls the line down
  always @(posedge mclk) begin
    if (reset) begin
      fault_n_o          <= 1'b0;
      fault_n_oe         <= 1'b0;
      overheat_warn_n_o  <= 1'b0;
      overheat_warn_n_oe <= 1'b0;
    end else begin
      fault_n_o          <= 1'b0;
      fault_n_oe         <= fault_now;
      overheat_warn_n_o  <= 1'b0;
      overheat_warn_n_oe <= hot_s;
    end
  end

  // interrupt events are rising edges of the protection conditions, but the current-limit event is set on every cycle a trip is seen
  wire [`BML_IRQ_W-1:0] irq_set;
  assign irq_set = {rsvd_mode & ~rsvd_d_r, hot_s & ~hot_d_r,
                    |trip_set, latch_any & ~latch_any_d_r};

  always @(posedge mclk) begin
    if (reset) begin
      hot_d_r       <= 1'b0;
      rsvd_d_r      <= 1'b0;
      latch_any_d_r <= 1'b0;
    end else begin
      hot_d_r       <= hot_s;
      rsvd_d_r      <= rsvd_mode;
      latch_any_d_r <= latch_any;
    end
  end

  // axi4-lite slave: one write and one read at a time
  reg                   aw_got_r;
  reg                   w_got_r;
  reg [`BML_ADDR_W-1:0] waddr_r;
  reg [31:0]            wdata_r;
  reg [3:0]             wstrb_r;
  wire                  do_write;
  wire                  aw_take;
  wire                  w_take;
  wire                  ar_take;

  assign aw_take  = s_axi_awvalid & s_axi_awready;
  assign w_take   = s_axi_wvalid & s_axi_wready;
  assign ar_take  = s_axi_arvalid & s_axi_arready;
  assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;

  // address and data are taken in either order; ready is a one-cycle
  // pulse so a second item cannot slip in before the response
  always @(posedge mclk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      waddr_r       <= {`BML_ADDR_W{1'b0}};
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_got_r & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid & ~s_axi_wready & ~w_got_r & ~s_axi_bvalid;
      if (aw_take) begin
        aw_got_r <= 1'b1;
        waddr_r  <= s_axi_awaddr[`BML_ADDR_W-1:0];
      end else if (do_write) begin
        aw_got_r <= 1'b0;
      end
      if (w_take) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // write side effects and response; set wins over a same-cycle clear
  always @(posedge mclk) begin
    if (reset) begin
      halt_r       <= `BML_CTRL_RST;
      irq_mask_r   <= `BML_IRQ_RST;
      irq_stat_r   <= `BML_IRQ_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BML_RESP_OKAY;
    end else begin
      if (do_write && wstrb_r[0] && (waddr_r == `BML_OFS_CTRL))
        halt_r <= wdata_r[`BML_CTRL_HALT_BIT];
      if (do_write && wstrb_r[0] && (waddr_r == `BML_OFS_IRQ_MASK))
        irq_mask_r <= wdata_r[`BML_IRQ_W-1:0];
      if (do_write && wstrb_r[0] && (waddr_r == `BML_OFS_IRQ_STAT))
        irq_stat_r <= (irq_stat_r & ~wdata_r[`BML_IRQ_W-1:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (waddr_r[1:0] != 2'h0) || (waddr_r == `BML_OFS_STATUS) ?
                        `BML_RESP_SLVERR : `BML_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux, unmapped words read zero with an error response
  reg [31:0] rd_word;
  reg        rd_err;
  always @* begin
    rd_word = 32'h00000000;
    rd_err  = 1'b0;
    case (s_axi_araddr[`BML_ADDR_W-1:0])
      `BML_OFS_CTRL:     rd_word[`BML_CTRL_HALT_BIT] = halt_r;
      `BML_OFS_STATUS: begin
        rd_word[`BML_ST_MODE_MSB:`BML_ST_MODE_LSB] = mode_s;
        rd_word[`BML_ST_RST_AB_BIT]   = rst_ab_n_s;
        rd_word[`BML_ST_RST_CD_BIT]   = rst_cd_n_s;
        rd_word[`BML_ST_LATCH_AB_BIT] = latch_ab_r;
        rd_word[`BML_ST_LATCH_CD_BIT] = latch_cd_r;
        rd_word[`BML_ST_RSVD_BIT]     = rsvd_mode;
        rd_word[`BML_ST_TRIP_MSB:`BML_ST_TRIP_LSB] = trip_r;
        rd_word[`BML_ST_FAULT_BIT]    = sy[`BML_SY_FAULT];
        rd_word[`BML_ST_WARN_BIT]     = sy[`BML_SY_WARN];
      end
      `BML_OFS_IRQ_STAT: rd_word[`BML_IRQ_W-1:0] = irq_stat_r;
      `BML_OFS_IRQ_MASK: rd_word[`BML_IRQ_W-1:0] = irq_mask_r;
      default:           rd_err = 1'b1;
    endcase
  end

  // read channel: data is captured at the address handshake
  always @(posedge mclk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `BML_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_err ? `BML_RESP_SLVERR : `BML_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // level interrupt, registered so the pin never glitches
  always @(posedge mclk) begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_r & irq_mask_r);
  end

endmodule // bml_top

`default_nettype wire

// ===== bml_top_properties.sv
/*
  bml_top_properties.sv - concurrent checks on the pin side of bml_top.
  Assumes pins held steady for four edges are fully through the synchronisers
  and that the control halt bit is set only while no routing check is armed.
*/
`timescale 1ns/10ps
`default_nettype none

module bml_top_properties (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // pins
  input wire logic [3:0] pwm_in,
  input wire logic       pair_one_reset_n,
  input wire logic       pair_two_reset_n,
  input wire logic       mode_sel_bit0,
  input wire logic       mode_sel_bit1,
  input wire logic       mode_sel_bit2,
  input wire logic [3:0] oc_detect,
  input wire logic       hot_detect,
  // half-bridge commands and open-drain pins
  input wire logic [3:0] hb_drive,
  input wire logic [3:0] hb_enable,
  input wire logic       fault_n_o,
  input wire logic       fault_n_oe,
  input wire logic       overheat_warn_n_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // pin mode and a clean run condition; oc must be quiet or a trip may hide demand
  wire [2:0] mode_pins = {mode_sel_bit2, mode_sel_bit1, mode_sel_bit0};
  // the edge that releases reset still clears the synchronisers, so it cannot open a window
  wire       run       = !reset && pair_one_reset_n && pair_two_reset_n &&
                         (oc_detect == 4'h0);

  a_pwm_routes: assert property ((mode_pins == 3'h0 && run && $stable(pwm_in))[*4]
    |-> hb_drive == pwm_in && hb_enable == 4'hF) else $error("direct routing wrong");
  a_parallel_pair: assert property ((mode_pins == 3'h2 && run && $stable(pwm_in))[*4]
    |-> hb_drive == {pwm_in[2], pwm_in[2], pwm_in[0], pwm_in[0]})
    else $error("paralleled routing wrong");
  a_compl_half: assert property ((mode_pins == 3'h3 && run && $stable(pwm_in))[*4]
    |-> hb_drive == {~pwm_in[2], pwm_in[2], ~pwm_in[0], pwm_in[0]})
    else $error("complementary routing wrong");
  a_pair_one_hold: assert property ((!pair_one_reset_n)[*4]
    |-> hb_enable[1:0] == 2'h0 && hb_drive[1:0] == 2'h0) else $error("pair one not held");
  a_pair_two_hold: assert property ((!pair_two_reset_n)[*4]
    |-> hb_enable[3:2] == 2'h0 && hb_drive[3:2] == 2'h0) else $error("pair two not held");
  a_rsvd_fault: assert property (mode_sel_bit2[*4]
    |-> fault_n_oe && !fault_n_o && hb_enable == 4'h0) else $error("reserved mode not off");
  a_latch_trip: assert property (mode_pins == 3'h1 && pair_one_reset_n && $rose(oc_detect[0])
    |-> ##4 hb_enable[1:0] == 2'h0 && fault_n_oe) else $error("latch shutdown missing");
  a_cbc_cut: assert property (mode_pins == 3'h0 && pair_one_reset_n && $rose(oc_detect[1])
    |-> ##3 !hb_drive[1] && hb_enable[1] && !fault_n_oe) else $error("current limit wrong");
  a_warn_on: assert property (hot_detect[*4] |-> overheat_warn_n_oe)
    else $error("warning not pulled");
  a_warn_off: assert property ((!hot_detect)[*4] |-> !overheat_warn_n_oe)
    else $error("warning stuck low");
endmodule // bml_top_properties

bind bml_top bml_top_properties bml_top_properties_inst (.*);

`default_nettype wire

// ===== bridge_mode_input_logic_tb.sv
/*
  bridge_mode_input_logic_tb.sv - directed bench: pin sequences and
  AXI4-Lite register calls with expected values.
  Assumes bml_top, bml_ctrl_model and the bound checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bml_map.vh"

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module bridge_mode_input_logic_tb;
  logic        mclk = 1'b0, reset = 1'b1, hot_detect = 1'b0;
  logic [3:0]  pwm_set = 4'h0, oc_detect = 4'h0, s_axi_wstrb = 4'hF;
  logic [2:0]  mode_set = 3'h0;
  logic        pair_one_reset_n = 1'b1, pair_two_reset_n = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         mode_sel_bit0 = mode_set[0], mode_sel_bit1 = mode_set[1];
  wire         mode_sel_bit2 = mode_set[2];
  wire  [3:0]  pwm_in, hb_drive, hb_enable;
  wire         fault_n_i, fault_n_o, fault_n_oe, irq, s_axi_awready, s_axi_wready;
  wire         overheat_warn_n_i, overheat_warn_n_o, overheat_warn_n_oe;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [31:0] s_axi_rdata;
  int          fail_count = 0, checked = 0, i;

  bml_top        bml_top_inst (.*);
  bml_ctrl_model bml_ctrl_model_inst (.*);

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // expected drive for a mode with both pairs running
  function automatic logic [3:0] route(input logic [1:0] m, input logic [3:0] p);
    case (m)
      2'h2: route = {p[2], p[2], p[0], p[0]};
      2'h3: route = {~p[2], p[2], ~p[0], p[0]};
      default: route = p;
    endcase
  endfunction

  // one write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle count assumed: only the watchdog ends a response that never comes
    while (!done) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
      end
    end
  endtask

  // one read, data and response taken at the rvalid edge
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit done;
    done = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
      end
    end
  endtask

  // set all pins, then give synchronisers, output flop and demand flop time;
  // the fifth edge lets a tripped half resume and arms the routing checks
  task automatic pins(input logic [2:0] m, input logic [1:0] rs, input logic [3:0] oc,
                      input logic [3:0] pw, input logic ht);
    @(posedge mclk);
    mode_set <= m;
    {pair_two_reset_n, pair_one_reset_n} <= rs;
    oc_detect <= oc;
    pwm_set <= pw;
    hot_detect <= ht;
    repeat (5) @(posedge mclk);
    #1;
  endtask

  task automatic end_of_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #50000;
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    axi_rd(`BML_OFS_CTRL, 32'h0, `BML_RESP_OKAY);
    axi_rd(`BML_OFS_STATUS, 32'h0000_3018, `BML_RESP_OKAY);
    axi_rd(`BML_OFS_IRQ_STAT, 32'h0, `BML_RESP_OKAY);
    axi_rd(`BML_OFS_IRQ_MASK, 32'h0, `BML_RESP_OKAY);
    axi_rd(32'h6, 32'h0, `BML_RESP_SLVERR);
    axi_wr(32'h2, 32'h1, `BML_RESP_SLVERR);
    axi_wr(`BML_OFS_STATUS, 32'hFFFF, `BML_RESP_SLVERR);
    axi_wr(`BML_OFS_IRQ_MASK, 32'hF, `BML_RESP_OKAY);
    axi_rd(`BML_OFS_IRQ_MASK, 32'hF, `BML_RESP_OKAY);
    // every defined mode with two demand patterns
    for (i = 0; i < 8; i++) begin
      pins({1'b0, i[2:1]}, 2'h3, 4'h0, i[0] ? 4'hE : 4'h1, 1'b0);
      `CHK("drive", route(i[2:1], i[0] ? 4'hE : 4'h1), hb_drive)
      `CHK("enable", 4'hF, hb_enable)
    end
    // halt bit turns every half off; done in mode 001, where no routing check is armed
    pins(3'h1, 2'h3, 4'h0, 4'hF, 1'b0);
    axi_wr(`BML_OFS_CTRL, 32'h1, `BML_RESP_OKAY);
    repeat (2) @(posedge mclk);
    `CHK("halt enable", 4'h0, hb_enable)
    `CHK("halt drive", 4'h0, hb_drive)
    axi_wr(`BML_OFS_CTRL, 32'h0, `BML_RESP_OKAY);
    // each pair reset alone
    pins(3'h0, 2'h2, 4'h0, 4'hF, 1'b0);
    `CHK("pair one", 4'hC, hb_enable & hb_drive)
    pins(3'h0, 2'h1, 4'h0, 4'hF, 1'b0);
    `CHK("pair two", 4'h3, hb_enable & hb_drive)
    // reserved mode: all off, fault pulled, interrupt raised then masked
    pins(3'h4, 2'h3, 4'h0, 4'hF, 1'b0);
    `CHK("rsvd enable", 4'h0, hb_enable)
    `CHK("rsvd fault", 1'b0, fault_n_i)
    `CHK("irq on", 1'b1, irq)
    axi_wr(`BML_OFS_IRQ_MASK, 32'h0, `BML_RESP_OKAY);
    repeat (2) @(posedge mclk);
    `CHK("irq masked", 1'b0, irq)
    axi_wr(`BML_OFS_IRQ_MASK, 32'hF, `BML_RESP_OKAY);
    pins(3'h0, 2'h3, 4'h0, 4'hF, 1'b0);
    axi_rd(`BML_OFS_IRQ_STAT, 32'h8, `BML_RESP_OKAY);
    axi_wr(`BML_OFS_IRQ_STAT, 32'h8, `BML_RESP_OKAY);
    repeat (2) @(posedge mclk);
    `CHK("irq cleared", 1'b0, irq)
    // latched shutdown survives the end of overcurrent until pair reset
    pins(3'h1, 2'h3, 4'h1, 4'hF, 1'b0);
    `CHK("latch enable", 4'hC, hb_enable)
    `CHK("latch fault", 1'b0, fault_n_i)
    pins(3'h1, 2'h3, 4'h0, 4'hF, 1'b0);
    `CHK("latch held", 4'hC, hb_enable)
    pins(3'h1, 2'h2, 4'h0, 4'hF, 1'b0);
    pins(3'h1, 2'h3, 4'h0, 4'hF, 1'b0);
    `CHK("latch freed", 4'hF, hb_enable)
    axi_rd(`BML_OFS_IRQ_STAT, 32'h1, `BML_RESP_OKAY);
    axi_wr(`BML_OFS_IRQ_STAT, 32'h1, `BML_RESP_OKAY);
    // cycle-by-cycle cut, released by the next rising demand
    pins(3'h0, 2'h3, 4'h2, 4'hF, 1'b0);
    `CHK("cbc drive", 4'hD, hb_drive)
    `CHK("cbc fault", 1'b1, fault_n_i)
    pins(3'h0, 2'h3, 4'h0, 4'hD, 1'b0);
    pins(3'h0, 2'h3, 4'h0, 4'hF, 1'b0);
    `CHK("cbc resume", 4'hF, hb_drive)
    axi_rd(`BML_OFS_IRQ_STAT, 32'h2, `BML_RESP_OKAY);
    axi_wr(`BML_OFS_IRQ_STAT, 32'h2, `BML_RESP_OKAY);
    // overtemperature warning
    pins(3'h0, 2'h3, 4'h0, 4'hF, 1'b1);
    `CHK("warn low", 1'b0, overheat_warn_n_i)
    `CHK("warn irq", 1'b1, irq)
    pins(3'h0, 2'h3, 4'h0, 4'hF, 1'b0);
    `CHK("warn high", 1'b1, overheat_warn_n_i)
    end_of_test();
  end
endmodule // bridge_mode_input_logic_tb

`default_nettype wire
